// File: pkg/oilm_pkg.sv
package oilm_pkg;

	// ======================================================
	// widths
	localparam int unsigned OILM_SRC_W = 8;
	localparam int unsigned OILM_DIR_W = 8;
	localparam int unsigned OILM_PIN_W = 3;

	// ======================================================
	// register addresses
	localparam logic [7:0] OILM_ADDR_STATUS = 8'h08;
	localparam logic [7:0] OILM_ADDR_LATCH_SET = 8'h0a;
	localparam logic [7:0] OILM_ADDR_LATCH_CLR = 8'h0b;
	localparam logic [7:0] OILM_ADDR_FALL_SET = 8'h0c;
	localparam logic [7:0] OILM_ADDR_FALL_CLR = 8'h0d;
	localparam logic [7:0] OILM_ADDR_RISE_SET = 8'h0e;
	localparam logic [7:0] OILM_ADDR_RISE_CLR = 8'h0f;
	localparam logic [7:0] OILM_ADDR_DIR_SET = 8'h14;
	localparam logic [7:0] OILM_ADDR_DIR_CLR = 8'h15;

	// ======================================================
	// reset values and fixed answers
	localparam logic [7:0] OILM_RST_LATCH = 8'h00;
	localparam logic [7:0] OILM_RST_MASK = 8'h00;
	localparam logic [7:0] OILM_RST_DIR = 8'h00;
	localparam logic [7:0] OILM_RD_UNMAPPED = 8'h00;

	// ======================================================
	// field positions
	localparam int unsigned OILM_SEL_BIT = 6;

	// ======================================================
	// carriers
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} oilm_req_t;

	// bit 0 is vbus_valid, bit 7 is car_kit_src
	typedef struct packed {
		logic car_kit_src;
		logic disc_conn;
		logic ident_open_src;
		logic minus_line_high_src;
		logic ident_grounded_src;
		logic plus_line_high_src;
		logic sess_valid;
		logic vbus_valid;
	} oilm_src_t;

endpackage

// File: verilog/oilm_setclr_reg.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// set/clear register with hardware set that beats a clear
module oilm_setclr_reg
	import oilm_pkg::*;
#(
	parameter int unsigned W = 8,
	parameter logic [W-1:0] RST = '0
)(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] set_i,
	input wire logic [W-1:0] clr_i,
	input wire logic [W-1:0] hw_set_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] q;
	} oilm_scr_st_t;

	oilm_scr_st_t st;
	oilm_scr_st_t next_st;

	// zero bits leave the value alone; set wins over clear
	always_comb
	begin
		next_st = st;
		next_st.q = (st.q & ~clr_i) | set_i | hw_set_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st <= '{q: RST};
		else
			st <= next_st;
	end

	assign q_o = st.q;
endmodule // oilm_setclr_reg
`default_nettype wire

// File: verilog/oilm_edge_det.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// masked rising / falling transition detector
module oilm_edge_det
	import oilm_pkg::*;
#(
	parameter int unsigned W = 8
)(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [W-1:0] src_i,
	input wire logic [W-1:0] rise_mask_i,
	input wire logic [W-1:0] fall_mask_i,
	output logic [W-1:0] edge_o
);
	typedef struct packed {
		logic primed;
		logic [W-1:0] prev;
	} oilm_edge_st_t;

	oilm_edge_st_t st;
	oilm_edge_st_t next_st;

	// remember last level; first sample after reset is no edge
	always_comb
	begin
		next_st.primed = 1'b1;
		next_st.prev = src_i;
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st <= '0;
		else
			st <= next_st;
	end

	// rising edges through one mask, falling through the other
	assign edge_o = {W{st.primed}}
		& ((~st.prev & src_i & rise_mask_i) | (st.prev & ~src_i & fall_mask_i));
endmodule // oilm_edge_det
`default_nettype wire

// File: verilog/oilm_top.sv
`timescale 1ns/100ps
`default_nettype none
module oilm_top
	import oilm_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire oilm_req_t reg_req_i,
	input wire oilm_src_t src_i,
	input wire logic sess_end_src_i,
	input wire logic disc_conn_en_i,
	input wire logic sess_end_sel_i,
	output logic [7:0] reg_rdata_o,
	output logic reg_rvalid_o,
	output logic [OILM_SRC_W-1:0] latch_o,
	output logic [OILM_SRC_W-1:0] fall_mask_o,
	output logic [OILM_SRC_W-1:0] rise_mask_o,
	output logic [OILM_PIN_W-1:0] pin_dir_o
);
	// ======================================================
	// state
	typedef struct packed {
		logic [7:0] rdata;
		logic rvalid;
		logic [OILM_PIN_W-1:0] pin_dir;
	} oilm_top_st_t;

	oilm_top_st_t st;
	oilm_top_st_t next_st;

	logic [OILM_SRC_W-1:0] src_vec;
	logic [OILM_SRC_W-1:0] edges;
	logic [OILM_DIR_W-1:0] dir_q;
	logic [OILM_SRC_W-1:0] latch_set;
	logic [OILM_SRC_W-1:0] latch_clr;
	logic [OILM_SRC_W-1:0] fall_set;
	logic [OILM_SRC_W-1:0] fall_clr;
	logic [OILM_SRC_W-1:0] rise_set;
	logic [OILM_SRC_W-1:0] rise_clr;
	logic [OILM_DIR_W-1:0] dir_set;
	logic [OILM_DIR_W-1:0] dir_clr;
	logic sel_sess_end;

	// ======================================================
	// source levels
	// bit 6 steered by the two control bits
	assign sel_sess_end = !disc_conn_en_i && sess_end_sel_i;

	always_comb
	begin
		src_vec = src_i;
		src_vec[OILM_SEL_BIT] = sel_sess_end ? sess_end_src_i : src_i.disc_conn;
	end

	// ======================================================
	// write strobes, one vector per address
	// request passed in, so every field change re-evaluates each strobe
	function automatic logic [7:0] oilm_hit(input oilm_req_t r, input logic [7:0] a);
		oilm_hit = (r.wr && r.addr == a) ? r.wdata : 8'h00;
	endfunction

	assign latch_set = oilm_hit(reg_req_i, OILM_ADDR_LATCH_SET);
	assign latch_clr = oilm_hit(reg_req_i, OILM_ADDR_LATCH_CLR);
	assign fall_set = oilm_hit(reg_req_i, OILM_ADDR_FALL_SET);
	assign fall_clr = oilm_hit(reg_req_i, OILM_ADDR_FALL_CLR);
	assign rise_set = oilm_hit(reg_req_i, OILM_ADDR_RISE_SET);
	assign rise_clr = oilm_hit(reg_req_i, OILM_ADDR_RISE_CLR);
	assign dir_set = oilm_hit(reg_req_i, OILM_ADDR_DIR_SET);
	assign dir_clr = oilm_hit(reg_req_i, OILM_ADDR_DIR_CLR);

	// ======================================================
	// mask registers
	oilm_setclr_reg #(
		.W(OILM_SRC_W),
		.RST(OILM_RST_MASK)
	) u_fall_mask (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.set_i(fall_set),
		.clr_i(fall_clr),
		.hw_set_i(8'h00),
		.q_o(fall_mask_o)
	);

	oilm_setclr_reg #(
		.W(OILM_SRC_W),
		.RST(OILM_RST_MASK)
	) u_rise_mask (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.set_i(rise_set),
		.clr_i(rise_clr),
		.hw_set_i(8'h00),
		.q_o(rise_mask_o)
	);

	// ======================================================
	// transition detection and latch
	oilm_edge_det #(
		.W(OILM_SRC_W)
	) u_edge (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.src_i(src_vec),
		.rise_mask_i(rise_mask_o),
		.fall_mask_i(fall_mask_o),
		.edge_o(edges)
	);

	// an edge in the clearing cycle still lands
	oilm_setclr_reg #(
		.W(OILM_SRC_W),
		.RST(OILM_RST_LATCH)
	) u_latch (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.set_i(latch_set),
		.clr_i(latch_clr),
		.hw_set_i(edges),
		.q_o(latch_o)
	);

	// ======================================================
	// pin direction, all eight bits stored
	oilm_setclr_reg #(
		.W(OILM_DIR_W),
		.RST(OILM_RST_DIR)
	) u_dir (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.set_i(dir_set),
		.clr_i(dir_clr),
		.hw_set_i(8'h00),
		.q_o(dir_q)
	);

	// ======================================================
	// read path, answer one cycle after the request
	always_comb
	begin
		next_st = st;
		next_st.rvalid = reg_req_i.rd;
		// pin direction copy so the port comes from a flop
		next_st.pin_dir = (dir_q[OILM_PIN_W-1:0] & ~dir_clr[OILM_PIN_W-1:0])
			| dir_set[OILM_PIN_W-1:0];
		if (reg_req_i.rd)
		begin
			case (reg_req_i.addr)
				OILM_ADDR_STATUS: next_st.rdata = src_vec;
				OILM_ADDR_LATCH_SET,
				OILM_ADDR_LATCH_CLR: next_st.rdata = latch_o;
				OILM_ADDR_FALL_SET,
				OILM_ADDR_FALL_CLR: next_st.rdata = fall_mask_o;
				OILM_ADDR_RISE_SET,
				OILM_ADDR_RISE_CLR: next_st.rdata = rise_mask_o;
				OILM_ADDR_DIR_SET,
				OILM_ADDR_DIR_CLR: next_st.rdata = dir_q;
				default: next_st.rdata = OILM_RD_UNMAPPED;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
			st <= '{rdata: OILM_RD_UNMAPPED, rvalid: 1'b0, pin_dir: OILM_RST_DIR[OILM_PIN_W-1:0]};
		else
			st <= next_st;
	end

	assign reg_rdata_o = st.rdata;
	assign reg_rvalid_o = st.rvalid;
	assign pin_dir_o = st.pin_dir;

	// ======================================================
	// checks
	default clocking oilm_cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	logic [OILM_SRC_W-1:0] fall_edges;
	assign fall_edges = u_edge.st.prev & ~src_vec & fall_mask_o & {OILM_SRC_W{u_edge.st.primed}};

	latch_set_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_LATCH_SET
		|=> (latch_o & $past(reg_req_i.wdata)) == $past(reg_req_i.wdata))
		else $error("latch set write did not set bits");

	latch_clr_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_LATCH_CLR && edges == 8'h00
		|=> (latch_o & $past(reg_req_i.wdata)) == 8'h00)
		else $error("latch clear write did not clear bits");

	fall_irq_a: assert property (
		fall_edges != 8'h00
		|=> (latch_o & $past(fall_edges)) == $past(fall_edges))
		else $error("enabled falling edge not latched");

	fall_set_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_FALL_SET
		|=> (fall_mask_o & $past(reg_req_i.wdata)) == $past(reg_req_i.wdata))
		else $error("falling mask set failed");

	rise_irq_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_RISE_SET && reg_req_i.wdata[0]
		##1 !src_vec[0] ##1 src_vec[0] && rise_mask_o[0]
		|=> latch_o[0])
		else $error("enabled rising edge not latched");

	mask_clr_a: assert property (
		reg_req_i.wr && (reg_req_i.addr == OILM_ADDR_FALL_CLR
		|| reg_req_i.addr == OILM_ADDR_RISE_CLR)
		|=> (($past(reg_req_i.addr) == OILM_ADDR_FALL_CLR ? fall_mask_o : rise_mask_o)
		& $past(reg_req_i.wdata)) == 8'h00)
		else $error("mask clear failed");

	dir_set_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_DIR_SET
		|=> (pin_dir_o & $past(reg_req_i.wdata[OILM_PIN_W-1:0]))
		== $past(reg_req_i.wdata[OILM_PIN_W-1:0]))
		else $error("pin not turned to output");

	dir_clr_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_DIR_CLR
		|=> (pin_dir_o & $past(reg_req_i.wdata[OILM_PIN_W-1:0])) == 3'h0)
		else $error("pin not returned to input");

	status_rd_a: assert property (
		reg_req_i.rd && reg_req_i.addr == OILM_ADDR_STATUS
		|=> reg_rvalid_o && reg_rdata_o == $past(src_vec))
		else $error("status read mismatch");

	sel_bit_a: assert property (
		reg_req_i.rd && reg_req_i.addr == OILM_ADDR_STATUS
		|=> reg_rdata_o[OILM_SEL_BIT] == $past(
		(!disc_conn_en_i && sess_end_sel_i) ? sess_end_src_i : src_i.disc_conn))
		else $error("bit 6 source selection wrong");

	latch_hold_a: assert property (
		!(reg_req_i.wr && reg_req_i.addr == OILM_ADDR_LATCH_CLR)
		|=> (latch_o & $past(latch_o)) == $past(latch_o))
		else $error("latch bit dropped without clear");

	zero_write_a: assert property (
		reg_req_i.wr && reg_req_i.wdata == 8'h00 && edges == 8'h00
		|=> $stable(latch_o) && $stable(fall_mask_o) && $stable(rise_mask_o)
		&& $stable(pin_dir_o))
		else $error("zero write changed a register");

	unmapped_a: assert property (
		reg_req_i.rd && reg_req_i.addr == 8'h00
		|=> reg_rdata_o == OILM_RD_UNMAPPED)
		else $error("unmapped read not zero");

	rise_set_a: assert property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_RISE_SET
		|=> (rise_mask_o & $past(reg_req_i.wdata)) == $past(reg_req_i.wdata))
		else $error("rising mask set failed");

	rd_pulse_a: assert property (
		reg_rvalid_o == $past(reg_req_i.rd))
		else $error("read answer not one cycle after request");

	latch_rd_a: assert property (
		reg_req_i.rd && (reg_req_i.addr == OILM_ADDR_LATCH_SET
		|| reg_req_i.addr == OILM_ADDR_LATCH_CLR)
		|=> reg_rdata_o == $past(latch_o))
		else $error("latch read mismatch");

	fall_rd_a: assert property (
		reg_req_i.rd && (reg_req_i.addr == OILM_ADDR_FALL_SET
		|| reg_req_i.addr == OILM_ADDR_FALL_CLR)
		|=> reg_rdata_o == $past(fall_mask_o))
		else $error("falling mask read mismatch");

	rise_rd_a: assert property (
		reg_req_i.rd && (reg_req_i.addr == OILM_ADDR_RISE_SET
		|| reg_req_i.addr == OILM_ADDR_RISE_CLR)
		|=> reg_rdata_o == $past(rise_mask_o))
		else $error("rising mask read mismatch");

	dir_rd_a: assert property (
		reg_req_i.rd && (reg_req_i.addr == OILM_ADDR_DIR_SET
		|| reg_req_i.addr == OILM_ADDR_DIR_CLR)
		|=> reg_rdata_o == $past(dir_q))
		else $error("direction read mismatch");

	latch_cause_a: assert property (
		(latch_o & ~$past(latch_o) & ~$past(latch_set) & ~$past(edges)) == 8'h00)
		else $error("latch bit set without a cause");

	// main scenarios
	rise_seen_c: cover property ((edges & ~fall_edges) != 8'h00 ##1 latch_o != 8'h00);
	fall_seen_c: cover property (fall_edges != 8'h00 ##1 latch_o != 8'h00);
	clr_race_c: cover property (
		reg_req_i.wr && reg_req_i.addr == OILM_ADDR_LATCH_CLR && edges != 8'h00);
	sess_sel_c: cover property (sel_sess_end && reg_req_i.rd
		&& reg_req_i.addr == OILM_ADDR_STATUS);
	pin_out_c: cover property (pin_dir_o == 3'h7);

endmodule // oilm_top
`default_nettype wire

// File: test/oilm_host.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// register-port host: one strobe per request
module oilm_host
	import oilm_pkg::*;
(
	input wire logic clk_i,
	output oilm_req_t req_o
);
	initial req_o = '0;

	// strobe one cycle, then idle with a scrambled bus
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
	begin
		@(negedge clk_i);
		req_o = {w, ~w, a, d};
		@(negedge clk_i);
		req_o = {2'b00, ~a, ~d};
	end
	endtask
endmodule // oilm_host
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
// ======================================================
// self-checking bench for the latch and mask block
module tb_top
	import oilm_pkg::*;
;
	logic clk_i, resetn_i, rvalid, sess_end, dc_en, es_sel;
	oilm_req_t req;
	oilm_src_t src;
	logic [7:0] rdata, latch, fmask, rmask, d, prev, cur;
	logic [2:0] pdir;
	logic [7:0] exp_q[$];
	logic [7:0] mdl[4];
	logic [7:0] sa[4] = '{OILM_ADDR_LATCH_SET, OILM_ADDR_FALL_SET,
		OILM_ADDR_RISE_SET, OILM_ADDR_DIR_SET};
	int num_errors, checks_done;

	oilm_top DUT (.clk_i(clk_i), .resetn_i(resetn_i), .reg_req_i(req), .src_i(src),
		.sess_end_src_i(sess_end), .disc_conn_en_i(dc_en), .sess_end_sel_i(es_sel),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .latch_o(latch),
		.fall_mask_o(fmask), .rise_mask_o(rmask), .pin_dir_o(pdir));
	oilm_host u_host (.clk_i(clk_i), .req_o(req));

	// 40 MHz clock
	initial
	begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// ======================================================
	// helpers
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("MISMATCH %s exp %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		u_host.xfer(1'b1, a, v);
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		u_host.xfer(1'b0, a, 8'h00);
	endtask

	// status value with bit 6 steered
	function automatic logic [7:0] eff();
		logic [7:0] v;
		v = src;
		if (!dc_en && es_sel) v[6] = sess_end;
		return v;
	endfunction

	task automatic print_verdict();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// read answers against the oldest note
	always @(negedge clk_i)
	begin
		if (rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("unasked_read", 8'h00, 8'h01);
			else
				check("rdata", rdata, exp_q.pop_front());
		end
	end

	// ======================================================
	// main sequence
	initial
	begin
		num_errors = 0;
		checks_done = 0;
		src = '0;
		{sess_end, dc_en, es_sel} = 3'h0;
		resetn_i = 1'b0;
		mdl = '{default: 8'h00};
		void'($urandom(35));
		repeat (20) @(posedge clk_i);
		@(negedge clk_i) resetn_i = 1'b1;
		// reset values, unmapped place, read-only status
		for (int i = 0; i < 4; i++)
		begin
			rd(sa[i], 8'h00);
			rd(sa[i] + 8'h01, 8'h00);
		end
		wr(OILM_ADDR_STATUS, 8'hff);
		rd(OILM_ADDR_STATUS, 8'h00);
		rd(8'h20, OILM_RD_UNMAPPED);
		// set, clear and zero writes on every pair
		for (int n = 0; n < 3; n++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				d = 8'($urandom);
				wr(sa[i], d);
				mdl[i] |= d;
				d = 8'($urandom);
				wr(sa[i] + 8'h01, d);
				mdl[i] &= ~d;
				wr(sa[i], 8'h00);
				wr(sa[i] + 8'h01, 8'h00);
				rd(sa[i], mdl[i]);
				rd(sa[i] + 8'h01, mdl[i]);
			end
			check("pin_dir", pdir, mdl[3][2:0]);
		end
		wr(sa[0] + 8'h01, 8'hff);
		mdl[0] = 8'h00;
		// source transitions under random masks
		for (int n = 0; n < 60; n++)
		begin
			if (n % 10 == 0)
			begin
				for (int i = 1; i < 3; i++)
				begin
					d = 8'($urandom);
					wr(sa[i], d);
					wr(sa[i] + 8'h01, ~d);
					mdl[i] = d;
				end
			end
			prev = eff();
			@(negedge clk_i);
			{src, sess_end, dc_en, es_sel} = 11'($urandom);
			cur = eff();
			mdl[0] |= (~prev & cur & mdl[2]) | (prev & ~cur & mdl[1]);
			rd(OILM_ADDR_STATUS, cur);
			check("latch", latch, mdl[0]);
			if (n % 7 == 6)
			begin
				d = 8'($urandom);
				wr(sa[0] + 8'h01, d);
				mdl[0] &= ~d;
				rd(sa[0], mdl[0]);
			end
		end
		check("fall_mask", fmask, mdl[1]);
		check("rise_mask", rmask, mdl[2]);
		for (int k = 0; k < 20 && exp_q.size() > 0; k++) @(negedge clk_i);
		if (exp_q.size() > 0)
			check("drain", 8'h00, 8'h01);
		print_verdict();
	end
endmodule // tb_top
`default_nettype wire
